// ### design/charger_status_pkg.sv
// constants, codes and carrier types for the charger status register group
package charger_status_pkg;

  // register offsets
  localparam logic [7:0] ADDR_BOOST = 8'h0a;
  localparam logic [7:0] ADDR_SRC   = 8'h0b;
  localparam logic [7:0] ADDR_FAULT = 8'h0c;

  // reset value of the boost setting register
  localparam logic [7:0] BOOST_RST = 8'h93;

  // field positions
  localparam int BOOST_LSB    = 4;
  localparam int SRC_TYPE_LSB = 5;
  localparam int PHASE_LSB    = 3;
  localparam int GOOD_BIT     = 2;
  localparam int GRADE_BIT    = 1;
  localparam int MINSYS_BIT   = 0;
  localparam int WD_BIT       = 7;
  localparam int BOOSTF_BIT   = 6;
  localparam int CHG_LSB      = 4;
  localparam int BATOV_BIT    = 3;
  localparam int TEMP_LSB     = 0;

  // boost target scaling in millivolts
  localparam logic [12:0] BOOST_OFFSET_MV = 13'd4550;
  localparam int          BOOST_STEP_LOG2 = 6;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_HOST, SRC_CHG_HOST, SRC_DEDICATED,
    SRC_HV_ADJ, SRC_UNKNOWN, SRC_NONSTD, SRC_OTG
  } source_type_t;

  typedef enum logic [1:0] {PH_IDLE, PH_PRE, PH_FAST, PH_DONE} charge_phase_t;

  typedef enum logic [1:0] {CF_NORMAL, CF_INPUT, CF_THERMAL, CF_TIMER} charge_fault_t;

  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_TXACK} i2c_state_t;

  typedef enum logic [1:0] {KIND_ADDR, KIND_PTR, KIND_DATA} byte_kind_t;

  // live conditions reported in the source and charge status register
  typedef struct packed {
    source_type_t  sourceType;
    charge_phase_t chargePhase;
    logic          inputGood;
    logic          hostHighCurrent;
    logic          batBelowMinSys;
  } status_in_t;

  // fault events and conditions
  typedef struct packed {
    logic       watchdogExpired;
    logic       boostMode;
    logic       otgOverload;
    logic       inputOvervoltage;
    logic       batTooLow;
    logic       inputFault;
    logic       thermalShutdown;
    logic       safetyTimerExpired;
    logic       batOvervoltage;
    logic [2:0] tempSensorCode;
  } fault_in_t;

  typedef struct packed {
    i2c_state_t st;
    byte_kind_t kind;
    logic [7:0] shreg;
    logic [2:0] bitCnt;
    logic       full;
    logic       rw;
    logic [7:0] ptr;
    logic       sdaLow;
    logic       sclPrev;
    logic       sdaPrev;
    logic [7:0] boostReg;
    logic [7:0] srcReg;
    logic [7:0] faultReg;
  } state_t;

  localparam state_t RST_STATE = '{
    st: I2C_IDLE, kind: KIND_ADDR, shreg: 8'h00, bitCnt: 3'h0, full: 1'b0,
    rw: 1'b0, ptr: 8'h00, sdaLow: 1'b0, sclPrev: 1'b1, sdaPrev: 1'b1,
    boostReg: BOOST_RST, srcReg: 8'h00, faultReg: 8'h00};

endpackage

// ### design/charger_status_regs.sv
// charger boost setting and status registers behind an i2c target port
// Notes on behaviour
// R1 - boost target is 4.55V plus 64mV per step of bits 7:4.
// R2 - boost register bits 3:2 reset to zero, bits 1:0 reset to one.
// R3 - source type is a 3-bit code, 000 none through 111 otg output.
// R4 - input current limit for the source lives elsewhere, not in the code.
// R5 - charge phase: 00 idle, 01 pre-charge, 10 fast, 11 terminated.
// R6 - grade bit: 0 low current host, 1 high; forced 1 unless code 001.
// R7 - min system regulation bit is 1 while battery below minimum system voltage.
// R8 - fault bit 7 reads 1 after watchdog expiry, 0 normally.
// R9 - boost fault bit 6 on overload, input overvoltage or low battery in boost.
// R10 - charge fault code: 00 normal, 01 input, 10 thermal, 11 safety timer.
// R11 - status and fault registers are read-only; writes leave them unchanged.
`timescale 1ns/1ps
module charger_status_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h35  // arbitrary default
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  // i2c pins, open drain data
  input  wire logic                          scl,
  input  wire logic                          sda,
  output logic                               sdaOut,
  output logic                               sdaOe,
  // charger state
  input  wire charger_status_pkg::status_in_t statusIn,
  input  wire charger_status_pkg::fault_in_t  faultIn,
  input  wire logic                          softReset,
  // boost setting to the converter
  output logic [12:0]                        boostTargetMv
);

  charger_status_pkg::state_t cur_ff;
  charger_status_pkg::state_t nxt_cur;

  logic        sclRise;
  logic        sclFall;
  logic        startCond;
  logic        stopCond;
  logic [7:0]  rdByte;
  logic        wrEn;
  logic        loadTx;
  logic        faultRd;
  logic [1:0]  chgCode;
  logic [7:0]  liveFault;

  assign sclRise   = scl & ~cur_ff.sclPrev;
  assign sclFall   = ~scl & cur_ff.sclPrev;
  assign startCond = scl & cur_ff.sclPrev & cur_ff.sdaPrev & ~sda;
  assign stopCond  = scl & cur_ff.sclPrev & ~cur_ff.sdaPrev & sda;

  assign sdaOut = 1'b0;
  assign sdaOe  = cur_ff.sdaLow;

  // R1 boost target scaling
  assign boostTargetMv = charger_status_pkg::BOOST_OFFSET_MV +
    13'({cur_ff.boostReg[charger_status_pkg::BOOST_LSB +: 4],
         {charger_status_pkg::BOOST_STEP_LOG2{1'b0}}});

  // unmapped offsets read as zero
  always_comb begin
    case (cur_ff.ptr)
      charger_status_pkg::ADDR_BOOST: rdByte = cur_ff.boostReg;
      charger_status_pkg::ADDR_SRC:   rdByte = cur_ff.srcReg;
      charger_status_pkg::ADDR_FAULT: rdByte = cur_ff.faultReg;
      default:                        rdByte = 8'h00;
    endcase
  end

  // R10 highest-coded fault wins when several are present
  always_comb begin
    if (faultIn.safetyTimerExpired) begin
      chgCode = charger_status_pkg::CF_TIMER;
    end else if (faultIn.thermalShutdown) begin
      chgCode = charger_status_pkg::CF_THERMAL;
    end else if (faultIn.inputFault) begin
      chgCode = charger_status_pkg::CF_INPUT;
    end else begin
      chgCode = charger_status_pkg::CF_NORMAL;
    end
  end

  always_comb begin
    liveFault = 8'h00;
    // R8 watchdog expiry
    liveFault[charger_status_pkg::WD_BIT] = faultIn.watchdogExpired;
    // R9 boost faults only count in boost mode
    liveFault[charger_status_pkg::BOOSTF_BIT] = faultIn.boostMode &
      (faultIn.otgOverload | faultIn.inputOvervoltage | faultIn.batTooLow);
    liveFault[charger_status_pkg::CHG_LSB +: 2] = chgCode;
    liveFault[charger_status_pkg::BATOV_BIT] = faultIn.batOvervoltage;
    liveFault[charger_status_pkg::TEMP_LSB +: 3] = faultIn.tempSensorCode;
  end

  always_comb begin
    nxt_cur = cur_ff;
    wrEn    = 1'b0;
    loadTx  = 1'b0;
    faultRd = 1'b0;
    nxt_cur.sclPrev = scl;
    nxt_cur.sdaPrev = sda;

    if (startCond) begin
      nxt_cur.st     = charger_status_pkg::I2C_RX;
      nxt_cur.kind   = charger_status_pkg::KIND_ADDR;
      nxt_cur.bitCnt = 3'h0;
      nxt_cur.full   = 1'b0;
      nxt_cur.sdaLow = 1'b0;
    end else if (stopCond) begin
      nxt_cur.st     = charger_status_pkg::I2C_IDLE;
      nxt_cur.sdaLow = 1'b0;
    end else begin
      case (cur_ff.st)
        charger_status_pkg::I2C_RX: begin
          if (sclRise) begin
            nxt_cur.shreg  = {cur_ff.shreg[6:0], sda};
            nxt_cur.bitCnt = cur_ff.bitCnt + 3'h1;
            nxt_cur.full   = (cur_ff.bitCnt == 3'h7);
          end
          if (sclFall && cur_ff.full) begin
            nxt_cur.full   = 1'b0;
            nxt_cur.st     = charger_status_pkg::I2C_ACK;
            nxt_cur.sdaLow = 1'b1;
            case (cur_ff.kind)
              charger_status_pkg::KIND_ADDR: begin
                nxt_cur.rw = cur_ff.shreg[0];
                // another target's address: stay silent until the next start
                if (cur_ff.shreg[7:1] != DEV_ADDR) begin
                  nxt_cur.st     = charger_status_pkg::I2C_IDLE;
                  nxt_cur.sdaLow = 1'b0;
                end
              end
              charger_status_pkg::KIND_PTR: begin
                nxt_cur.ptr = cur_ff.shreg;
              end
              default: begin
                wrEn        = 1'b1;
                nxt_cur.ptr = cur_ff.ptr + 8'h01;
              end
            endcase
          end
        end
        charger_status_pkg::I2C_ACK: begin
          if (sclFall) begin
            nxt_cur.sdaLow = 1'b0;
            nxt_cur.bitCnt = 3'h0;
            if (cur_ff.kind == charger_status_pkg::KIND_ADDR && cur_ff.rw) begin
              loadTx = 1'b1;
            end else begin
              nxt_cur.st   = charger_status_pkg::I2C_RX;
              nxt_cur.kind = (cur_ff.kind == charger_status_pkg::KIND_ADDR) ?
                             charger_status_pkg::KIND_PTR : charger_status_pkg::KIND_DATA;
            end
          end
        end
        charger_status_pkg::I2C_TX: begin
          if (sclFall) begin
            nxt_cur.bitCnt = cur_ff.bitCnt + 3'h1;
            if (cur_ff.bitCnt == 3'h7) begin
              nxt_cur.sdaLow = 1'b0;
              nxt_cur.st     = charger_status_pkg::I2C_TXACK;
            end else begin
              nxt_cur.shreg  = {cur_ff.shreg[6:0], 1'b0};
              nxt_cur.sdaLow = ~cur_ff.shreg[6];
            end
          end
        end
        charger_status_pkg::I2C_TXACK: begin
          if (sclRise) begin
            if (sda) begin
              nxt_cur.st = charger_status_pkg::I2C_IDLE;
            end else begin
              nxt_cur.ptr  = cur_ff.ptr + 8'h01;
              nxt_cur.full = 1'b1;
            end
          end
          if (sclFall && cur_ff.full) begin
            nxt_cur.full   = 1'b0;
            nxt_cur.bitCnt = 3'h0;
            loadTx         = 1'b1;
          end
        end
        default: begin
          nxt_cur.st = charger_status_pkg::I2C_IDLE;
        end
      endcase
    end

    // the byte is captured whole so a read never sees a half-updated register
    if (loadTx) begin
      nxt_cur.shreg  = rdByte;
      nxt_cur.sdaLow = ~rdByte[7];
      nxt_cur.st     = charger_status_pkg::I2C_TX;
      faultRd        = (cur_ff.ptr == charger_status_pkg::ADDR_FAULT);
    end

    // R11 only the boost register accepts data
    if (wrEn && cur_ff.ptr == charger_status_pkg::ADDR_BOOST) begin
      nxt_cur.boostReg = cur_ff.shreg;
    end
    // R2 software reset and watchdog expiry restore defaults, overriding a write
    if (softReset || faultIn.watchdogExpired) begin
      nxt_cur.boostReg = charger_status_pkg::BOOST_RST;
    end

    // R3 R5 R7 live status
    nxt_cur.srcReg[charger_status_pkg::SRC_TYPE_LSB +: 3] = statusIn.sourceType;
    nxt_cur.srcReg[charger_status_pkg::PHASE_LSB +: 2]    = statusIn.chargePhase;
    nxt_cur.srcReg[charger_status_pkg::GOOD_BIT]          = statusIn.inputGood;
    nxt_cur.srcReg[charger_status_pkg::MINSYS_BIT]        = statusIn.batBelowMinSys;
    // R6 grade only meaningful for a plain host port
    // R4 the granted current limit is reported by the input limit register
    nxt_cur.srcReg[charger_status_pkg::GRADE_BIT] =
      (statusIn.sourceType != charger_status_pkg::SRC_HOST) | statusIn.hostHighCurrent;

    // R8 R9 R10 faults hold until read; a new event in the read cycle survives
    nxt_cur.faultReg = (faultRd ? 8'h00 : cur_ff.faultReg) | liveFault;
    if (liveFault[charger_status_pkg::CHG_LSB +: 2] != 2'b00 || faultRd) begin
      nxt_cur.faultReg[charger_status_pkg::CHG_LSB +: 2] = chgCode;
    end
    if (liveFault[charger_status_pkg::TEMP_LSB +: 3] != 3'b000 || faultRd) begin
      nxt_cur.faultReg[charger_status_pkg::TEMP_LSB +: 3] = faultIn.tempSensorCode;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur_ff <= charger_status_pkg::RST_STATE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_boost_full_scale: assert property ( // R1
    cur_ff.boostReg[7:4] == 4'hf |-> boostTargetMv == 13'd5510)
    else $error("boost target wrong at full scale");
  a_boost_reset_val: assert property ( // R2
    $rose(rstn) |-> cur_ff.boostReg == 8'h93 && boostTargetMv == 13'd5126)
    else $error("boost register reset value wrong");
  a_boost_wd_default: assert property ( // R2
    faultIn.watchdogExpired |=> cur_ff.boostReg[3:0] == 4'h3)
    else $error("boost reserved bits not restored");
  a_source_code_track: assert property ( // R3
    1'b1 |=> cur_ff.srcReg[7:5] == $past(statusIn.sourceType))
    else $error("source type code not reported");
  a_phase_code_track: assert property ( // R5
    1'b1 |=> cur_ff.srcReg[4:3] == $past(statusIn.chargePhase))
    else $error("charge phase not reported");
  a_grade_forced_one: assert property ( // R6
    statusIn.sourceType != charger_status_pkg::SRC_HOST |=> cur_ff.srcReg[1])
    else $error("grade bit not forced for non host source");
  a_minsys_flag: assert property ( // R7
    statusIn.batBelowMinSys |=> cur_ff.srcReg[0])
    else $error("min system flag missing");
  a_wd_fault_sticky: assert property ( // R8
    faultIn.watchdogExpired ##1 !faultRd [*2] |-> cur_ff.faultReg[7])
    else $error("watchdog fault lost before read");
  a_boost_fault_set: assert property ( // R9
    faultIn.boostMode && faultIn.batTooLow |=> cur_ff.faultReg[6])
    else $error("boost fault not flagged");
  a_timer_fault_code: assert property ( // R10
    faultIn.safetyTimerExpired |=> cur_ff.faultReg[5:4] == 2'b11)
    else $error("safety timer code wrong");
  a_ro_write_ignored: assert property ( // R11
    wrEn && cur_ff.ptr != charger_status_pkg::ADDR_BOOST && !softReset
      && !faultIn.watchdogExpired |=> $stable(cur_ff.boostReg))
    else $error("write to read-only offset changed setting");

  c_boost_write: cover property (wrEn && cur_ff.ptr == charger_status_pkg::ADDR_BOOST);
  c_fault_read:  cover property (faultRd && cur_ff.faultReg != 8'h00);
  c_read_nack:   cover property (cur_ff.st == charger_status_pkg::I2C_TXACK && sclRise && sda);
  c_burst_read:  cover property (loadTx && cur_ff.st == charger_status_pkg::I2C_TXACK);

endmodule

// ### test/charger_status_regs_bench.sv
// self-checking bench for the charger status register group
`timescale 1ns/1ps
module charger_status_regs_bench;
  localparam logic [6:0] DEV = 7'h35;
  logic                           ref_clk;
  logic                           rstn;
  logic                           scl;
  logic                           sdaDrv;
  logic                           sdaLine;
  logic                           sdaOut;
  logic                           sdaOe;
  logic                           softReset;
  logic [12:0]                    boostTargetMv;
  charger_status_pkg::status_in_t statusIn;
  charger_status_pkg::fault_in_t  faultIn;
  int                             bad_count = 0;
  int                             checks_done = 0;
  int                             expAck = 0;

  // open drain wire with a pull-up
  assign sdaLine = sdaOe ? (sdaOut & sdaDrv) : sdaDrv;

  charger_status_regs #(.DEV_ADDR(DEV)) dut (.ref_clk(ref_clk), .rstn(rstn), .scl(scl),
    .sda(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .statusIn(statusIn), .faultIn(faultIn),
    .softReset(softReset), .boostTargetMv(boostTargetMv));

  i2c_host_model host (.ref_clk(ref_clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));

  function automatic logic [7:0] srcExp(charger_status_pkg::status_in_t s);
    return {s.sourceType, s.chargePhase, s.inputGood,
            (s.sourceType != charger_status_pkg::SRC_HOST) | s.hostHighCurrent, s.batBelowMinSys};
  endfunction

  function automatic logic [7:0] faultExp(charger_status_pkg::fault_in_t f);
    logic [1:0] cf;
    cf = f.safetyTimerExpired ? 2'h3 : f.thermalShutdown ? 2'h2 : {1'b0, f.inputFault};
    return {f.watchdogExpired, f.boostMode & (f.otgOverload | f.inputOvervoltage | f.batTooLow),
            cf, f.batOvervoltage, f.tempSensorCode};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wrReg(input logic [7:0] p, input logic [7:0] v);
    host.wr(DEV, p, {v});
    expAck += 3;
  endtask

  task automatic rdReg(input logic [7:0] p, input logic [7:0] e);
    host.rdn(DEV, p, 1);
    expAck += 3;
    check(16'(host.rd[0]), 16'(e));
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    bad_count++;
    close_out();
  end

  initial begin
    logic [7:0]  v;
    logic [11:0] ft [9];
    ft = '{12'h000, 12'h040, 12'h020, 12'h010, 12'h200, 12'h600, 12'h500, 12'h480, 12'h80d};
    rstn = 1'b0;
    softReset = 1'b0;
    statusIn = '0;
    faultIn = '0;
    v = 8'($urandom(32'h0c37));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check(16'(boostTargetMv), 16'd5126);
    rdReg(8'h0a, 8'h93);
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'hf0 : 8'($urandom);
      wrReg(8'h0a, v);
      check(16'(boostTargetMv), 16'(4550 + 64 * v[7:4]));
      rdReg(8'h0a, v);
    end
    softReset <= 1'b1;
    @(posedge ref_clk);
    softReset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdReg(8'h0a, 8'h93);
    for (int k = 0; k < 16; k++) begin
      statusIn <= {3'(k), 2'(k >> 1), 1'($urandom), k[3], 1'($urandom)};
      repeat (2) @(posedge ref_clk);
      rdReg(8'h0b, srcExp(statusIn));
    end
    wrReg(8'h0b, ~srcExp(statusIn));
    rdReg(8'h0b, srcExp(statusIn));
    // first read flushes sticky history, second shows the live faults
    for (int k = 0; k < 14; k++) begin
      faultIn <= (k < 9) ? ft[k] : 12'($urandom);
      repeat (2) @(posedge ref_clk);
      host.rdn(DEV, 8'h0c, 1);
      expAck += 3;
      rdReg(8'h0c, faultExp(faultIn));
    end
    faultIn <= '0;
    wrReg(8'h0a, 8'h5a);
    // sticky bits and latched codes from the random sweep must go before the watchdog case
    host.rdn(DEV, 8'h0c, 1);
    expAck += 3;
    faultIn <= 12'h800;
    @(posedge ref_clk);
    faultIn <= '0;
    repeat (2) @(posedge ref_clk);
    check(16'(boostTargetMv), 16'd5126);
    rdReg(8'h0c, 8'h80);
    rdReg(8'h0c, 8'h00);
    wrReg(8'h0c, 8'hff);
    rdReg(8'h0c, 8'h00);
    host.wr(DEV, 8'h0a, {8'h3c, 8'h77});
    host.rdn(DEV, 8'h0a, 3);
    expAck += 7;
    check(16'(host.rd[0]), 16'h003c);
    check(16'(host.rd[1]), 16'(srcExp(statusIn)));
    check(16'(host.rd[2]), 16'h0000);
    rdReg(8'h20, 8'h00);
    host.wr(7'h36, 8'h0a, {8'h00});
    check(16'(boostTargetMv), 16'(4550 + 64 * 3));
    check(16'(host.ackCount), 16'(expAck));
    close_out();
  end
endmodule

// ### test/i2c_host_model.sv
// i2c host model that reaches the charger registers over the two-wire port
`timescale 1ns/1ps
module i2c_host_model (
  // clock
  input  wire logic ref_clk,
  // bus wires
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaDrv
);
  logic [7:0] rd [4];
  int         ackCount;

  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    ackCount = 0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // data moves only mid-low so the target never sees a false start or stop
  task automatic bitOut(input logic b);
    scl <= 1'b0;
    tick(3);
    sdaDrv <= b;
    tick(3);
    scl <= 1'b1;
    tick(6);
  endtask

  // released line floats to the pull-up, never to a stale level
  task automatic bitIn(output logic b);
    scl <= 1'b0;
    tick(3);
    sdaDrv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    b = sdaLine;
    tick(3);
  endtask

  task automatic frameStart();
    scl <= 1'b0;
    tick(3);
    sdaDrv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sdaDrv <= 1'b0;
    tick(4);
  endtask

  task automatic frameStop();
    scl <= 1'b0;
    tick(3);
    sdaDrv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sdaDrv <= 1'b1;
    tick(4);
  endtask

  task automatic sendByte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitOut(v[i]);
    end
    bitIn(a);
    if (a === 1'b0) begin
      ackCount++;
    end
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d[$]);
    frameStart();
    sendByte({dev, 1'b0});
    sendByte(ptr);
    foreach (d[i]) begin
      sendByte(d[i]);
    end
    frameStop();
  endtask

  // last byte is refused so the target lets go of the line before stop
  task automatic rdn(input logic [6:0] dev, input logic [7:0] ptr, input int n);
    frameStart();
    sendByte({dev, 1'b0});
    sendByte(ptr);
    frameStart();
    sendByte({dev, 1'b1});
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) begin
        bitIn(rd[i][j]);
      end
      bitOut(i == n - 1);
    end
    frameStop();
  endtask
endmodule
